// ### rtl/sswr_top.v
// Supply supervisor, manual reset, watchdog, aux flag and write guard
`timescale 1ns/1ps
`default_nettype none
`include "sswr_consts.vh"
module sswr_top #(
    parameter WATCHDOG_VARIANT = 1,
    parameter [25:0] RST_DELAY_CYC = `SSWR_RST_DELAY_CYC,
    parameter [25:0] WDOG_CYC = `SSWR_WDOG_CYC
) (
    input wire I_CLK,
    input wire I_RESET,
    input wire I_SUPPLY_OK,
    input wire I_AUX_SENSE_INPUT,
    input wire I_WATCHDOG_KICK_INPUT,
    input wire I_RESET_N_PIN,
    output reg O_RESET_N_OE_N,
    output reg O_RESET_HI,
    output reg O_RESET_HI_EN,
    output reg O_AUX_LOW_FLAG_OE_N,
    input wire I_WR_REQ,
    input wire [`SSWR_PAGE_AW-1:0] I_WR_ADDR,
    input wire [7:0] I_WR_DATA,
    input wire [`SSWR_PAGE_AW-1:0] I_RD_ADDR,
    output wire [7:0] O_RD_DATA,
    output reg O_WR_BLOCKED,
    input wire I_SDA_DRIVE_LOW,
    output wire O_SDA_OUT,
    output reg O_SDA_OE_N
);
    // Counter step, saturating at zero
    function [25:0] cnt_dec;
        input [25:0] v;
        begin
            cnt_dec = (v == 26'h0000000) ? 26'h0000000 : v - 26'h0000001;
        end
    endfunction

    // Reload value of a down counter
    function [25:0] cnt_load;
        input [25:0] v;
        begin
            cnt_load = v - 26'h0000001;
        end
    endfunction

    // Active-high reset output exists
    localparam HAS_HI = (WATCHDOG_VARIANT == 0) ? 1'b1 : 1'b0;

    // Synchronised inputs, kick history and delayed own release
    reg sup_s1_r;
    reg sup_s2_r;
    reg aux_s1_r;
    reg aux_s2_r;
    reg kick_s1_r;
    reg kick_s2_r;
    reg kick_d_r;
    reg pin_s1_r;
    reg pin_s2_r;
    reg own_d1_r;
    reg own_d2_r;

    // Input synchronisers
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            aux_s1_r <= 1'b0;
            aux_s2_r <= 1'b0;
            kick_s1_r <= 1'b0;
            kick_s2_r <= 1'b0;
            kick_d_r <= 1'b0;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            sup_s1_r <= I_SUPPLY_OK;
            sup_s2_r <= sup_s1_r;
            aux_s1_r <= I_AUX_SENSE_INPUT;
            aux_s2_r <= aux_s1_r;
            kick_s1_r <= I_WATCHDOG_KICK_INPUT;
            kick_s2_r <= kick_s1_r;
            kick_d_r <= kick_s2_r;
            pin_s1_r <= I_RESET_N_PIN;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Own release delayed by the pin synchroniser depth
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            own_d1_r <= 1'b0;
            own_d2_r <= 1'b0;
        end else begin
            own_d1_r <= O_RESET_N_OE_N;
            own_d2_r <= own_d1_r;
        end
    end

    // Kick edge from synchronised input
    wire kick_edge = kick_s2_r ^ kick_d_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [25:0] dly_r;
    reg [25:0] dly_nxt;
    reg [25:0] wd_r;
    reg [25:0] wd_nxt;
    reg asserted_nxt;
    // Own low drive still in synchroniser is masked
    // pin low while released
    wire manual_req = ~pin_s2_r & O_RESET_N_OE_N & own_d1_r & own_d2_r;
    // Watchdog expiry without a kick
    wire wd_expire = (WATCHDOG_VARIANT != 0) &&
        (state_r == `SSWR_ST_RUN) &&
        (wd_r == 26'h0000000) &&
        !kick_edge;

    // Next-state logic
    always @* begin
        state_nxt = state_r;
        dly_nxt = dly_r;
        wd_nxt = wd_r;
        case (state_r)
            `SSWR_ST_HOLD: begin
                dly_nxt = cnt_load(RST_DELAY_CYC);
                if (sup_s2_r) begin
                    state_nxt = `SSWR_ST_DELAY;
                end
            end
            `SSWR_ST_DELAY: begin
                dly_nxt = cnt_dec(dly_r);
                if (!sup_s2_r || manual_req) begin
                    state_nxt = `SSWR_ST_HOLD;
                end else if (dly_r == 26'h0000000) begin
                    state_nxt = `SSWR_ST_RUN;
                    wd_nxt = cnt_load(WDOG_CYC);
                end
            end
            `SSWR_ST_RUN: begin
                wd_nxt = kick_edge ? cnt_load(WDOG_CYC) : cnt_dec(wd_r);
                if (!sup_s2_r || manual_req || wd_expire) begin
                    state_nxt = `SSWR_ST_HOLD;
                end
            end
            default: begin
                state_nxt = `SSWR_ST_HOLD;
            end
        endcase
        if (state_nxt != `SSWR_ST_RUN) begin
            wd_nxt = 26'h0000000;
        end
        asserted_nxt = (state_nxt != `SSWR_ST_RUN);
    end

    // State and counter registers
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_r <= `SSWR_ST_HOLD;
            dly_r <= 26'h0000000;
            wd_r <= 26'h0000000;
        end else begin
            state_r <= state_nxt;
            dly_r <= dly_nxt;
            wd_r <= wd_nxt;
        end
    end

    // Output registers
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_RESET_N_OE_N <= 1'b0;
            O_RESET_HI <= 1'b1;
            O_RESET_HI_EN <= 1'b1;
            O_AUX_LOW_FLAG_OE_N <= 1'b0;
            O_WR_BLOCKED <= 1'b1;
            O_SDA_OE_N <= 1'b1;
        end else begin
            O_RESET_N_OE_N <= ~asserted_nxt;
            O_RESET_HI <= HAS_HI & asserted_nxt;
            O_RESET_HI_EN <= HAS_HI;
            // flag low while aux is low
            O_AUX_LOW_FLAG_OE_N <= aux_s2_r;
            O_WR_BLOCKED <= ~sup_s2_r;
            O_SDA_OE_N <= ~I_SDA_DRIVE_LOW;
        end
    end

    assign O_SDA_OUT = 1'b0;

    wire wr_en = I_WR_REQ & ~O_WR_BLOCKED & sup_s2_r;

    sswr_page_mem u_page (
        .i_clk(I_CLK),
        .i_we(wr_en),
        .i_waddr(I_WR_ADDR),
        .i_wdata(I_WR_DATA),
        .i_raddr(I_RD_ADDR),
        .o_rdata(O_RD_DATA)
    );
endmodule
`default_nettype wire

// ### rtl/sswr_consts.vh
// Constants of the supply supervisor and watchdog reset block
`ifndef SSWR_CONSTS_VH
`define SSWR_CONSTS_VH
`define SSWR_CLK_HZ 25000000
`define SSWR_RST_DELAY_MS 200
`define SSWR_WDOG_TIMEOUT_MS 1600
`define SSWR_RST_DELAY_CYC ((`SSWR_CLK_HZ / 1000) * `SSWR_RST_DELAY_MS)
`define SSWR_WDOG_CYC ((`SSWR_CLK_HZ / 1000) * `SSWR_WDOG_TIMEOUT_MS)
`define SSWR_CNT_W 26
`define SSWR_PAGE_BYTES 16
`define SSWR_PAGE_AW 4
`define SSWR_ST_HOLD 2'h0
`define SSWR_ST_DELAY 2'h1
`define SSWR_ST_RUN 2'h2
`endif

// ### rtl/sswr_page_mem.v
// Sixteen-byte page write buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "sswr_consts.vh"
module sswr_page_mem (
    input wire i_clk,
    input wire i_we,
    input wire [`SSWR_PAGE_AW-1:0] i_waddr,
    input wire [7:0] i_wdata,
    input wire [`SSWR_PAGE_AW-1:0] i_raddr,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:`SSWR_PAGE_BYTES-1];
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// ### test/sswr_props.sv
// Checker on the supervisor block ports
`timescale 1ns/1ps
`default_nettype none
module sswr_props #(parameter [25:0] RST_DELAY_CYC = 26'h0000014,
    parameter [25:0] WDOG_CYC = 26'h000003C) (
    input wire logic I_CLK, I_RESET, I_SUPPLY_OK, I_AUX_SENSE_INPUT, I_WATCHDOG_KICK_INPUT,
    input wire logic O_RESET_N_OE_N, O_RESET_HI, O_RESET_HI_EN, O_AUX_LOW_FLAG_OE_N,
    input wire logic O_WR_BLOCKED, I_SDA_DRIVE_LOW, O_SDA_OUT, O_SDA_OE_N);
localparam int RD = RST_DELAY_CYC, WD = WDOG_CYC;
int q_r = 0;
default clocking cb @(posedge I_CLK); endclocking
default disable iff (I_RESET);
// Cycles since release or last kick edge
always @(posedge I_CLK) q_r <= (!O_RESET_N_OE_N || $changed(I_WATCHDOG_KICK_INPUT)) ? 0 : q_r + 1;
sequence s_gone; $fell(I_SUPPLY_OK) ##1 !I_SUPPLY_OK [*2]; endsequence
chk_supply_drop: assert property (s_gone |-> ##[0:2] !O_RESET_N_OE_N) else $error("drop");
chk_release_delay: assert property ($rose(O_RESET_N_OE_N) |-> $past(I_SUPPLY_OK, RD))
    else $error("early");
chk_wdog_bite: assert property (O_RESET_N_OE_N |-> q_r <= WD + 5) else $error("bite");
chk_aux_low: assert property ($fell(I_AUX_SENSE_INPUT) |-> ##3 !O_AUX_LOW_FLAG_OE_N)
    else $error("aux");
chk_aux_high: assert property ($rose(I_AUX_SENSE_INPUT) |-> ##3 O_AUX_LOW_FLAG_OE_N)
    else $error("aux");
chk_write_guard: assert property (!I_SUPPLY_OK [*4] |-> O_WR_BLOCKED) else $error("wr");
chk_sda_drain: assert property (I_SDA_DRIVE_LOW |=> !O_SDA_OE_N && !O_SDA_OUT)
    else $error("sda");
chk_hi_absent: assert property (!$past(I_RESET) |-> !O_RESET_HI_EN && !O_RESET_HI)
    else $error("hi");
endmodule
bind sswr_top sswr_props #(.RST_DELAY_CYC(RST_DELAY_CYC), .WDOG_CYC(WDOG_CYC)) chk_u (.I_CLK,
    .I_RESET, .I_SUPPLY_OK, .I_AUX_SENSE_INPUT, .I_WATCHDOG_KICK_INPUT, .O_RESET_N_OE_N,
    .O_RESET_HI, .O_RESET_HI_EN, .O_AUX_LOW_FLAG_OE_N, .O_WR_BLOCKED, .I_SDA_DRIVE_LOW,
    .O_SDA_OUT, .O_SDA_OE_N);
`default_nettype wire

// ### test/sswr_host.sv
// Host model: kicks and reset wire
`timescale 1ns/1ps
`default_nettype none
module sswr_host (input wire logic i_clk, i_on, i_push, i_oe_n,
    output logic o_kick, output wire logic o_pin);
logic [3:0] n_r = 4'h0;
initial o_kick = 1'b0;
assign o_pin = i_oe_n & ~i_push;
always @(negedge i_clk) begin
    n_r <= n_r + 4'h1;
    if (i_on && n_r == 4'hF) o_kick <= ~o_kick;
end
endmodule
`default_nettype wire

// ### test/sswr_top_bench.sv
// Bench of the supervisor block
`timescale 1ns/1ps
`default_nettype none
module sswr_top_bench;
localparam int RD = 20, WD = 60;
logic clk = 0, rst = 1, sup = 0, aux = 0, kon = 1, push = 0, wr = 0, sl = 0;
logic [3:0] wa = 4'h0, ra = 4'h0;
logic [7:0] wd = 8'h00;
wire kick, pin, oe_n, hi, hen, fl, blk, so, soe;
wire [7:0] rd;
int err_total = 0, comparisons = 0, k;
initial forever #20 clk = ~clk;
sswr_top #(.RST_DELAY_CYC(26'h0000014), .WDOG_CYC(26'h000003C)) dut_u (.I_CLK(clk),
    .I_RESET(rst), .I_SUPPLY_OK(sup), .I_AUX_SENSE_INPUT(aux), .I_WATCHDOG_KICK_INPUT(kick),
    .I_RESET_N_PIN(pin), .O_RESET_N_OE_N(oe_n), .O_RESET_HI(hi), .O_RESET_HI_EN(hen),
    .O_AUX_LOW_FLAG_OE_N(fl), .I_WR_REQ(wr), .I_WR_ADDR(wa), .I_WR_DATA(wd), .I_RD_ADDR(ra),
    .O_RD_DATA(rd), .O_WR_BLOCKED(blk), .I_SDA_DRIVE_LOW(sl), .O_SDA_OUT(so), .O_SDA_OE_N(soe));
sswr_host host_u (.i_clk(clk), .i_on(kon), .i_push(push), .i_oe_n(oe_n), .o_kick(kick),
    .o_pin(pin));
task automatic cmp(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
        err_total++;
        $display("mismatch %s exp %h seen %h", n, e, s);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(negedge clk);
endtask
task automatic wt(input logic v);
    k = 0;
    while (oe_n !== v && k < 300) begin
        cyc(1);
        k++;
    end
    cmp("wait", k < 300, 1);
endtask
task automatic t_power;
    cyc(4);
    cmp("held", {hen, hi, oe_n, blk}, 8'h01);
    sup = 1;
    wt(1);
    cmp("delay", k >= RD && k <= RD + 8, 1);
    $display("power done");
endtask
task automatic t_aux;
    aux = 1; cyc(5); cmp("aux", fl, 1);
    aux = 0; cyc(5); cmp("aux", fl, 0);
    aux = 1; cyc(5); $display("aux done");
endtask
task automatic t_mem;
    for (int i = 0; i < 16; i++) begin
        wr = 1; wa = i[3:0]; wd = 8'hA0 ^ i[7:0]; cyc(1);
    end
    wr = 0;
    for (int i = 0; i < 16; i++) begin
        ra = i[3:0]; cyc(1); cmp("page", rd, 8'hA0 ^ i[7:0]);
    end
    sup = 0; cyc(5); cmp("low", {oe_n, blk}, 8'h01);
    wr = 1; wa = 4'h3; cyc(1); wr = 0; ra = 4'h3; cyc(2);
    cmp("guard", rd, 8'hA3);
    sup = 1; wt(1); $display("mem done");
endtask
task automatic t_sda;
    sl = 1; cyc(2); cmp("sda", {soe, so}, 8'h00);
    sl = 0; cyc(2); cmp("sda", {soe, so}, 8'h02);
    $display("sda done");
endtask
task automatic t_man;
    push = 1; cyc(3); cmp("man", oe_n, 0);
    push = 0; wt(1); cmp("hold", k >= RD, 1);
    $display("manual done");
endtask
task automatic t_wdog;
    cyc(3 * WD); cmp("alive", oe_n, 1);
    kon = 0; wt(0); cmp("bite", k >= WD - 20 && k <= WD + 6, 1);
    wt(1); wt(0); cmp("fresh", k >= WD - 2 && k <= WD + 6, 1);
    kon = 1; wt(1); $display("watchdog done");
endtask
task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
initial begin
    cyc(8); rst = 0;
    t_power; t_aux; t_mem; t_sda; t_man; t_wdog;
    close_out;
end
initial begin
    #400000; err_total++; close_out;
end
endmodule
`default_nettype wire
